// [tics_map.vh]
// constants for the table i/o character sequencer: register map, field layout, packing
`ifndef TICS_MAP_VH
`define TICS_MAP_VH

// register byte offsets on the avalon-mm slave
`define TICS_REG_CTRL   4'h0
`define TICS_REG_BASE   4'h4
`define TICS_REG_STAT   4'h8
`define TICS_REG_PEND   4'hc

// control register fields and reset values
`define TICS_CTRL_EN_BIT 0
`define TICS_CTRL_RST    1'h0
`define TICS_BASE_RST    14'h0000

// status register field positions
`define TICS_STAT_BUSY_BIT  0
`define TICS_STAT_CH_LO     8
`define TICS_STAT_CNT_LO    16

// control word layout in the 24-bit memory word
`define TICS_N_HI 23
`define TICS_N_LO 18
`define TICS_C_HI 17
`define TICS_C_LO 16
`define TICS_P_HI 15
`define TICS_P_LO 14
`define TICS_Y_HI 13
`define TICS_Y_LO 0

// word count value that marks the end of a block
`define TICS_N_DONE 6'h3f

// packing codes, twos complement of characters per word
`define TICS_PACK_4 2'h0
`define TICS_PACK_3 2'h1
`define TICS_PACK_2 2'h2
`define TICS_PACK_1 2'h3

// left circular rotation per character, by packing
`define TICS_ROT_4 5'h06
`define TICS_ROT_3 5'h08
`define TICS_ROT_2 5'h0c
`define TICS_ROT_1 5'h00

// character masks in the low bits, by packing
`define TICS_MASK_4 24'h00003f
`define TICS_MASK_3 24'h0000ff
`define TICS_MASK_2 24'h000fff
`define TICS_MASK_1 24'hffffff

`endif

// [tics_rotate.v]
// circular left rotator and character mask for the b register path
`timescale 1ns/1ns
`include "tics_map.vh"

module tics_rotate (
  data,
  pack,
  rot,
  mask
);
  input  wire [23:0] data;  // b register contents
  input  wire [1:0]  pack;  // packing field
  output wire [23:0] rot;   // rotated word
  output reg  [23:0] mask;  // one character in the low bits

  reg  [4:0]  amt;          // rotate distance
  wire [47:0] dbl;          // doubled word, shifted

  // distance and mask chosen by characters per word
  always @* begin
    case (pack)
      `TICS_PACK_4: begin
        amt  = `TICS_ROT_4;
        mask = `TICS_MASK_4;
      end
      `TICS_PACK_3: begin
        amt  = `TICS_ROT_3;
        mask = `TICS_MASK_3;
      end
      `TICS_PACK_2: begin
        amt  = `TICS_ROT_2;
        mask = `TICS_MASK_2;
      end
      default: begin
        amt  = `TICS_ROT_1; // single character, no rotation
        mask = `TICS_MASK_1;
      end
    endcase
  end

  // shifting the doubled word gives the circular rotation in the top half
  assign dbl = {data, data} << amt;
  assign rot = dbl[47:24];

endmodule

// [tics_sequencer.v]
// table i/o character sequencer: interrupt driven packing and unpacking of device characters
`timescale 1ns/1ns
`include "tics_map.vh"

module tics_sequencer #(
  parameter NCH         = 48,            // number of channels
  parameter CHW         = 6,             // channel index width
  parameter [NCH-1:0] CH_IS_INPUT = {NCH{1'b0}} // per-channel direction wiring
) (
  clk,
  rstn,
  ce,
  chan_irq,
  dev_in_data,
  dev_code,
  dev_dir_in,
  dev_in_ack,
  dev_out_data,
  dev_out_stb,
  echo_irq,
  echo_code,
  mem_req,
  mem_we,
  mem_addr,
  mem_wdata,
  mem_rdata,
  mem_ack,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest
);
  input  wire           clk;             // 10 mhz system clock
  input  wire           rstn;            // async reset, active low
  input  wire           ce;              // clock enable, freezes state when low
  input  wire [NCH-1:0] chan_irq;        // device interrupt per channel, async pins
  input  wire [23:0]    dev_in_data;     // character from input device, async pins
  output reg  [CHW-1:0] dev_code;        // addressed device code
  output reg            dev_dir_in;      // high: input transfer, low: output
  output reg            dev_in_ack;      // pulse: input character taken
  output reg  [23:0]    dev_out_data;    // character to output device
  output reg            dev_out_stb;     // pulse: output character valid
  output reg            echo_irq;        // pulse: block complete
  output reg  [CHW-1:0] echo_code;       // channel that completed
  output reg            mem_req;         // core memory request
  output reg            mem_we;          // core memory write
  output reg  [13:0]    mem_addr;        // core memory address
  output reg  [23:0]    mem_wdata;       // core memory write data
  input  wire [23:0]    mem_rdata;       // core memory read data
  input  wire           mem_ack;         // memory takes request this edge
  input  wire [3:0]     avs_address;     // byte address of register
  input  wire           avs_read;        // avalon read
  input  wire           avs_write;       // avalon write
  input  wire [31:0]    avs_writedata;   // avalon write data
  input  wire [3:0]     avs_byteenable;  // avalon byte lanes
  output reg  [31:0]    avs_readdata;    // avalon read data
  output reg            avs_waitrequest; // avalon stall, low for one cycle per answer

  // sequencer states
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_FETCH = 3'h1;
  localparam [2:0] S_UPD   = 3'h2;
  localparam [2:0] S_WCTL  = 3'h3;
  localparam [2:0] S_RDAT  = 3'h4;
  localparam [2:0] S_XFER  = 3'h5;
  localparam [2:0] S_WDAT  = 3'h6;

  reg            rst_s1_r;     // reset release stage one
  reg            rst_n_r;      // synchronised reset, active low
  reg  [2:0]     state_r;      // sequencer state
  reg  [23:0]    ctl_r;        // control word being serviced
  reg  [23:0]    b_r;          // b register
  reg            first_r;      // first character of the word
  reg            echo_pend_r;  // block ends with this service
  reg  [CHW-1:0] cur_ch_r;     // channel in service
  reg            en_r;         // software enable
  reg  [13:0]    base_r;       // base of response addresses
  reg  [15:0]    echo_cnt_r;   // completed blocks
  reg  [CHW-1:0] last_ch_r;    // last completed channel
  reg  [23:0]    din_s1_r;     // device data sync stage one
  reg  [23:0]    din_s2_r;     // device data sync stage two
  reg  [23:0]    din_s3_r;     // device data sync stage three
  reg  [23:0]    din_r;        // agreed device data
  wire [NCH-1:0] pend_w;       // pending channel requests
  reg            pick;         // some channel pending
  reg  [CHW-1:0] pick_ch;      // lowest pending channel
  wire           svc_clr;      // pending bit taken into service
  wire [23:0]    rot_w;        // rotated b register
  wire [23:0]    mask_w;       // character mask
  integer        k;            // priority scan index

  // reset release through two flip-flops; left ungated so ce cannot hold reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // per-channel interrupt synchroniser and sticky pending bit
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      reg s1_r;   // stage one, read only by stage two
      reg s2_r;   // stage two
      reg s3_r;   // stage three
      reg lvl_r;  // agreed level
      reg pend_r; // request waiting for service
      always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          s1_r   <= 1'b0;
          s2_r   <= 1'b0;
          s3_r   <= 1'b0;
          lvl_r  <= 1'b0;
          pend_r <= 1'b0;
        end else if (ce) begin
          s1_r <= chan_irq[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
          // a new rising edge beats the clear of the same cycle
          if ((s2_r == s3_r) && s3_r && !lvl_r) begin
            pend_r <= 1'b1;
          end else if (svc_clr && (pick_ch == gi)) begin
            pend_r <= 1'b0;
          end
        end
      end
      assign pend_w[gi] = pend_r;
    end
  endgenerate

  // device data pins: three stages, taken once stages two and three agree
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      din_s1_r <= 24'h000000;
      din_s2_r <= 24'h000000;
      din_s3_r <= 24'h000000;
      din_r    <= 24'h000000;
    end else if (ce) begin
      din_s1_r <= dev_in_data;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
      if (din_s2_r == din_s3_r) begin
        din_r <= din_s3_r;
      end
    end
  end

  // fixed priority: lowest channel number wins
  always @* begin
    pick    = 1'b0;
    pick_ch = {CHW{1'b0}};
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (pend_w[k]) begin
        pick    = 1'b1;
        pick_ch = k[CHW-1:0];
      end
    end
  end

  assign svc_clr = ce && (state_r == S_IDLE) && en_r && pick;

  // control word fields
  wire [5:0]  n_f = ctl_r[`TICS_N_HI:`TICS_N_LO];
  wire [1:0]  c_f = ctl_r[`TICS_C_HI:`TICS_C_LO];
  wire [1:0]  p_f = ctl_r[`TICS_P_HI:`TICS_P_LO];
  wire [13:0] y_f = ctl_r[`TICS_Y_HI:`TICS_Y_LO];

  // control word update arithmetic
  wire        first_w = (c_f == p_f);
  wire [2:0]  c_inc   = {1'b0, c_f} + 3'h1;
  wire        c_carry = c_inc[2];
  wire [1:0]  c_new   = (c_inc[1:0] == 2'h0) ? p_f : c_inc[1:0];
  wire [5:0]  n_new   = c_carry ? n_f + 6'h01 : n_f;
  wire [13:0] y_new   = first_w ? y_f + 14'h0001 : y_f;
  wire        echo_w  = c_carry && (n_new == `TICS_N_DONE);
  wire [23:0] ctl_new = {n_new, c_new, p_f, y_new};
  wire [13:0] resp_addr = base_r + {{(14-CHW){1'b0}}, cur_ch_r};

  // character path: rotate then merge or pick the low character
  tics_rotate u_rot (
    .data (b_r),
    .pack (p_f),
    .rot  (rot_w),
    .mask (mask_w)
  );

  // input merges device character into the rotated word through the adder path
  wire [23:0] b_in  = rot_w | (din_r & mask_w);
  wire [23:0] b_nxt = dev_dir_in ? b_in : rot_w;

  // sequencer: fetch, update, write back, then data word
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r      <= S_IDLE;
      ctl_r        <= 24'h000000;
      b_r          <= 24'h000000;
      first_r      <= 1'b0;
      echo_pend_r  <= 1'b0;
      cur_ch_r     <= {CHW{1'b0}};
      dev_code     <= {CHW{1'b0}};
      dev_dir_in   <= 1'b0;
      dev_in_ack   <= 1'b0;
      dev_out_data <= 24'h000000;
      dev_out_stb  <= 1'b0;
      echo_irq     <= 1'b0;
      echo_code    <= {CHW{1'b0}};
      echo_cnt_r   <= 16'h0000;
      last_ch_r    <= {CHW{1'b0}};
      mem_req      <= 1'b0;
      mem_we       <= 1'b0;
      mem_addr     <= 14'h0000;
      mem_wdata    <= 24'h000000;
    end else if (ce) begin
      // pulses last one cycle
      dev_in_ack  <= 1'b0;
      dev_out_stb <= 1'b0;
      echo_irq    <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (en_r && pick) begin
            // matrix wiring: code is the channel, direction from parameter
            cur_ch_r   <= pick_ch;
            dev_code   <= pick_ch;
            dev_dir_in <= CH_IS_INPUT[pick_ch];
            mem_req    <= 1'b1;
            mem_we     <= 1'b0;
            mem_addr   <= base_r + {{(14-CHW){1'b0}}, pick_ch};
            state_r    <= S_FETCH;
          end
        end
        S_FETCH: begin
          // control word read from the channel response address
          if (mem_ack) begin
            mem_req <= 1'b0;
            ctl_r   <= mem_rdata;
            state_r <= S_UPD;
          end
        end
        S_UPD: begin
          ctl_r       <= ctl_new;
          first_r     <= first_w;
          echo_pend_r <= echo_w;
          mem_req     <= 1'b1;
          mem_we      <= 1'b1;
          mem_addr    <= resp_addr;
          mem_wdata   <= ctl_new;
          state_r     <= S_WCTL;
        end
        S_WCTL: begin
          // data word is touched only after the control word is home
          if (mem_ack) begin
            mem_we   <= 1'b0;
            mem_addr <= y_f;
            state_r  <= S_RDAT;
          end
        end
        S_RDAT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            // a fresh input word starts from zero, not stale memory
            if (dev_dir_in && first_r) begin
              b_r <= 24'h000000;
            end else begin
              b_r <= mem_rdata;
            end
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          // only b and the adder path are used; no program registers
          b_r <= b_nxt;
          if (dev_dir_in) begin
            dev_in_ack <= 1'b1;
          end else begin
            dev_out_data <= rot_w & mask_w;
            dev_out_stb  <= 1'b1;
          end
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= y_f;
          mem_wdata <= b_nxt;
          state_r   <= S_WDAT;
        end
        S_WDAT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            if (echo_pend_r) begin
              echo_irq   <= 1'b1;
              echo_code  <= cur_ch_r;
              last_ch_r  <= cur_ch_r;
              echo_cnt_r <= echo_cnt_r + 16'h0001;
            end
            state_r <= S_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // avalon slave: waitrequest drops for one cycle, one cycle after the request
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      en_r            <= `TICS_CTRL_RST;
      base_r          <= `TICS_BASE_RST;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            `TICS_REG_CTRL: avs_readdata <= {31'h00000000, en_r};
            `TICS_REG_BASE: avs_readdata <= {18'h00000, base_r};
            `TICS_REG_STAT: begin
              avs_readdata[`TICS_STAT_BUSY_BIT] <= (state_r != S_IDLE);
              avs_readdata[`TICS_STAT_CH_LO +: CHW] <= last_ch_r;
              avs_readdata[`TICS_STAT_CNT_LO +: 16] <= echo_cnt_r;
            end
            `TICS_REG_PEND: avs_readdata <= pend_w[31:0];
            default: avs_readdata <= 32'h00000000; // unmapped reads zero
          endcase
        end
      end else begin
        avs_waitrequest <= 1'b1;
        // write takes effect at the edge where waitrequest is seen low
        if (avs_write && !avs_waitrequest) begin
          case (avs_address)
            `TICS_REG_CTRL: begin
              if (avs_byteenable[0]) begin
                en_r <= avs_writedata[`TICS_CTRL_EN_BIT];
              end
            end
            `TICS_REG_BASE: begin
              if (avs_byteenable[0]) begin
                base_r[7:0] <= avs_writedata[7:0];
              end
              if (avs_byteenable[1]) begin
                base_r[13:8] <= avs_writedata[13:8];
              end
            end
            default: begin
              // read-only and unmapped writes are dropped
            end
          endcase
        end
      end
    end
  end

endmodule

// [tics_sequencer_sva.sv]
// port checker for the sequencer: bus answer, memory order, control word update
`timescale 1ns/1ns
module tics_sequencer_chk (
  input wire        clk,
  input wire        rstn,
  input wire        ce,
  input wire        dev_dir_in,
  input wire        dev_in_ack,
  input wire        dev_out_stb,
  input wire        echo_irq,
  input wire        mem_req,
  input wire        mem_we,
  input wire [13:0] mem_addr,
  input wire [23:0] mem_wdata,
  input wire [23:0] mem_rdata,
  input wire        mem_ack,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest
);
  reg  [1:0]  step_r;    // access number inside one service
  reg  [13:0] adr_r;     // where the control word came from
  reg  [23:0] ctl_r;     // control word as fetched
  reg  [23:0] new_r;     // control word as written back
  wire        take  = mem_req && mem_ack;                   // memory takes a request
  wire [2:0]  c_inc = {1'b0, ctl_r[17:16]} + 3'h1;          // count plus one, carry on top
  wire [13:0] y_upd = ctl_r[13:0] + {13'h0000, ctl_r[17:16] == ctl_r[15:14]};
  // follow the read, write, read, write order; any extra access misaligns it and fires
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_r <= 2'h0;
      adr_r  <= 14'h0000;
      ctl_r  <= 24'h000000;
      new_r  <= 24'h000000;
    end else if (take) begin
      step_r <= step_r + 2'h1;
      if (step_r == 2'h0) begin
        adr_r <= mem_addr;
        ctl_r <= mem_rdata;
      end
      if (step_r == 2'h1) begin
        new_r <= mem_wdata;
      end
    end
  end
  default clocking dflt @(posedge clk);
  endclocking
  default disable iff (!rstn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("register access not answered after one cycle");
  bus_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
    else $error("memory request changed before it was taken");
  mem_order_a: assert property (take |-> mem_we == step_r[0])
    else $error("memory accesses out of order");
  ctl_back_a: assert property (take && step_r == 2'h1 |-> mem_addr == adr_r)
    else $error("control word written to another address");
  ctl_count_a: assert property (take && step_r == 2'h1 |-> mem_wdata[23:14] ==
      {ctl_r[23:18] + {5'h00, c_inc[2]}, (c_inc[1:0] == 2'h0) ? ctl_r[15:14] : c_inc[1:0], ctl_r[15:14]})
    else $error("counts in written control word wrong");
  ctl_addr_a: assert property (take && step_r == 2'h1 |-> mem_wdata[13:0] == y_upd)
    else $error("table address in written control word wrong");
  table_addr_a: assert property (take && step_r[1] |-> mem_addr == new_r[13:0])
    else $error("data word access off the updated table address");
  out_dir_a: assert property (dev_out_stb |-> !dev_dir_in ##1 !dev_out_stb)
    else $error("output strobe on an input channel or too long");
  in_dir_a: assert property (dev_in_ack |-> dev_dir_in ##1 !dev_in_ack)
    else $error("input take on an output channel or too long");
  store_after_a: assert property (dev_out_stb || dev_in_ack |-> ##[0:300] (take && mem_we && step_r == 2'h3))
    else $error("data word not stored after the character moved");
  echo_cause_a: assert property (echo_irq |-> step_r == 2'h0 && new_r[23:18] == 6'h3f &&
      new_r[17:16] == new_r[15:14] ##1 !echo_irq)
    else $error("completion pulse without a finished block");
endmodule
bind tics_sequencer tics_sequencer_chk tics_sequencer_chk_inst (
  .clk(clk), .rstn(rstn), .ce(ce), .dev_dir_in(dev_dir_in), .dev_in_ack(dev_in_ack), .dev_out_stb(dev_out_stb),
  .echo_irq(echo_irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest)
);

// [tics_mem_model.sv]
// core memory stand-in with prompt or late answers
`timescale 1ns/1ns
module tics_mem_model (
  input  wire        clk,
  input  wire        slow,       // high: three wait cycles per request
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [13:0] mem_addr,
  input  wire [23:0] mem_wdata,
  output wire [23:0] mem_rdata,
  output wire        mem_ack
);
  reg [23:0] mem [0:16383];        // core words, preloaded by the bench
  reg [1:0]  wait_r;               // waits spent on the current request
  reg [23:0] junk_r = 24'h5a5a5a;  // undriven read bus, changes every cycle
  assign mem_ack   = mem_req && (!slow || wait_r == 2'h3);
  // read data only at the taking edge, so a late sample sees garbage
  assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr] : junk_r;
  // count waits, commit writes, keep the idle bus moving
  always @(posedge clk) begin
    junk_r <= ~junk_r ^ {mem_addr, 10'h155};
    wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
    if (mem_ack && mem_we)
      mem[mem_addr] <= mem_wdata;
  end
endmodule

// [tics_sequencer_test.sv]
// bench for the sequencer: registers, output and input table transfers
`timescale 1ns/1ns
`include "tics_map.vh"
`define TICS_CHK(got, exp) \
  begin \
    n_checks = n_checks + 1; \
    if ((got) !== (exp)) begin \
      error_cnt = error_cnt + 1; \
      $display("FAIL at %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tics_sequencer_test;
  reg         clk = 1'b0;            // 10 mhz clock
  reg         rstn = 1'b0;           // reset, low at start
  reg  [47:0] chan_irq = 48'h0;      // device interrupts
  reg  [23:0] dev_in_data = 24'h0;   // character from input device
  reg  [3:0]  avs_address = 4'h0;    // register bus request
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg         slow = 1'b0;           // memory answers late
  reg  [31:0] q;                     // last register read
  reg  [23:0] got_r;                 // character at last strobe
  reg  [6:0]  who_r;                 // code and direction at last strobe
  reg         armed = 1'b0;          // sequencer enabled
  reg  [5:0]  n;                     // bench copy of control word fields
  reg  [1:0]  c;
  reg  [1:0]  p;
  reg  [13:0] y;
  reg         dir;                   // case is an input transfer
  wire [5:0]  dev_code;
  wire [5:0]  echo_code;
  wire        dev_dir_in, dev_in_ack, dev_out_stb, echo_irq, mem_req, mem_we, mem_ack, avs_waitrequest;
  wire [23:0] dev_out_data, mem_wdata, mem_rdata;
  wire [13:0] mem_addr;
  wire [31:0] avs_readdata;
  integer     error_cnt = 0, n_checks = 0, ech = 0, echoes = 0, wr_cnt = 0, i, k;
  // channel 1 wired as input, the rest output
  tics_sequencer #(.CH_IS_INPUT(48'h000000000002)) tics_sequencer_inst (
    .clk(clk), .rstn(rstn), .ce(1'b1), .chan_irq(chan_irq), .dev_in_data(dev_in_data), .dev_code(dev_code),
    .dev_dir_in(dev_dir_in), .dev_in_ack(dev_in_ack), .dev_out_data(dev_out_data), .dev_out_stb(dev_out_stb),
    .echo_irq(echo_irq), .echo_code(echo_code), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  tics_mem_model tics_mem_model_inst (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial forever #50 clk = ~clk;
  // count writes and echoes, keep what each strobe carried
  always @(posedge clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (echo_irq === 1'b1)
      echoes <= echoes + 1;
    if (dev_out_stb === 1'b1 || dev_in_ack === 1'b1) begin
      got_r <= dev_out_data;
      who_r <= {dev_code, dev_dir_in};
    end
  end
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // one register access, held until waitrequest is sampled low
  task bus(input rd, input [3:0] a, input [31:0] wd);
    begin
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= wd;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  // one interrupt on channel ch; the bench works the control word out first
  task serve(input [5:0] ch, input [23:0] din);
    reg        first, carry;
    reg [23:0] w, m;
    integer    wd, w0;
    begin
      first = (c == p);
      if (first)
        y = y + 14'h1;
      {carry, c} = {1'b0, c} + 3'h1;
      if (carry)
        n = n + 6'h1;
      if (c == 2'h0)
        c = p;
      wd = 24 / (4 - p);
      m = (wd == 24) ? 24'hffffff : (24'h1 << wd) - 24'h1;
      w = (dir && first) ? 24'h0 : tics_mem_model_inst.mem[y];
      if (wd != 24)
        w = (w << wd) | (w >> (24 - wd));
      if (dir)
        w = w | (din & m);
      w0 = wr_cnt;
      dev_in_data <= din & m;
      chan_irq[ch] <= 1'b1;
      // first request waits pending while the sequencer is off
      if (!armed) begin
        repeat (8) @(posedge clk);
        bus(1'b1, `TICS_REG_PEND, 32'h0);
        `TICS_CHK(q, 32'h00000001)
        bus(1'b0, `TICS_REG_CTRL, 32'h00000001);
        armed = 1'b1;
      end
      while (wr_cnt != w0 + 2)
        @(posedge clk);
      chan_irq[ch] <= 1'b0;
      repeat (2) @(posedge clk);
      `TICS_CHK(tics_mem_model_inst.mem[14'h0100 + {8'h00, ch}], {n, c, p, y})
      `TICS_CHK(tics_mem_model_inst.mem[y], w)
      `TICS_CHK(who_r, {ch, dir})
      if (!dir)
        `TICS_CHK(got_r, w & m)
      if (carry && n == 6'h3f) begin
        ech = ech + 1;
        `TICS_CHK(echo_code, ch)
      end
      `TICS_CHK(echoes, ech)
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b1, `TICS_REG_CTRL, 32'h0);
    `TICS_CHK(q, 32'h00000000)
    bus(1'b1, `TICS_REG_BASE, 32'h0);
    `TICS_CHK(q, 32'h00000000)
    bus(1'b0, `TICS_REG_BASE, 32'h00000100);
    bus(1'b1, `TICS_REG_BASE, 32'h0);
    `TICS_CHK(q, 32'h00000100)
    bus(1'b1, 4'h2, 32'h0);
    `TICS_CHK(q, 32'h00000000)
    // four output packings on channel 0, then two input packings on channel 1
    for (i = 0; i < 6; i = i + 1) begin
      dir = (i > 3);
      p = (i == 4) ? 2'h0 : (i == 5) ? 2'h2 : i[1:0];
      n = (i == 2) ? 6'h3d : 6'h3e;
      c = p;
      y = 14'h01ff + {i[11:0], 2'h0};
      slow <= i[0];
      tics_mem_model_inst.mem[14'h0100 + {13'h0000, dir}] = {n, c, p, y};
      tics_mem_model_inst.mem[y + 14'h1] = 24'hc5a3e7;
      tics_mem_model_inst.mem[y + 14'h2] = 24'h3b1d96;
      // count fixed once up front: serve advances n, so a live bound would stop a block early
      for (k = (4 - p) * (63 - n); k > 0; k = k - 1)
        serve({5'h00, dir}, 24'h9e37b5 >> k);
    end
    bus(1'b1, `TICS_REG_STAT, 32'h0);
    `TICS_CHK(q, {16'h0006, 2'h0, 6'h01, 8'h00})
    close_out;
  end
  // hang guard: the tests need about four hundred cycles
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    close_out;
  end
endmodule
